// [verilog/xssr_top.v]
// extended state save/restore engine with an axi4-lite control slave
// assumes a word-wide memory port toward the save area with a one-cycle ack
//
// Operation
// RULE_01 - header sits 512 bytes into area
// RULE_02 - header opens with 64-bit present vector
// RULE_03 - present bits mirror feature enable bits
// RULE_04 - save sets present bit of written component
// RULE_05 - save touches only mask-and-enable bits
// RULE_06 - software edits need present bit set
// RULE_07 - optimized save only after plain save
// RULE_08 - restore updates only mask-and-enable components
// RULE_09 - present component loads from save area
// RULE_10 - absent component gets fixed initial values
// RULE_11 - media init: sixteen in 64-bit, else eight
// RULE_12 - upper-half init: sixteen in 64-bit, else eight
// RULE_13 - media control always loaded from memory
// RULE_14 - capability clear: pointers only with pending error
// RULE_15 - capability set: always load, zero selectors; the code zeroes cs and ds only in 64-bit mode and loads them from the image outside it
// RULE_16 - capability set: save zeros unless error pending
// RULE_17 - media eight to fifteen skipped outside 64-bit
// RULE_18 - upper halves eight to fifteen skipped likewise
// RULE_19 - restore ignores legacy bytes 464 to 511
// RULE_20 - stack slots at 0x20, media at 0xa0
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "xssr_consts.vh"

module xssr_top (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire [31:0] mem_rdata,
	input  wire        mem_ack
);
	localparam S_IDLE = 3'd0;
	localparam S_HREQ = 3'd1;
	localparam S_HWAIT = 3'd2;
	localparam S_PREP = 3'd3;
	localparam S_LOAD = 3'd4;
	localparam S_BUS = 3'd5;

	localparam A_SKIP = 2'd0;
	localparam A_MEM = 2'd1;
	localparam A_INIT = 2'd2;

	// byte-lane merge used by the mask, feature enable and base registers
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// full tag word to one bit per register: empty (11) becomes 0
	function [7:0] tag_abridge;
		input [15:0] tw;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				tag_abridge[i] = ~(tw[2*i] & tw[2*i+1]);
			end
		end
	endfunction

	// back to a full tag word; a full register comes back as valid (lossy)
	function [15:0] tag_expand;
		input [7:0] tb;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				tag_expand[2*i +: 2] = tb[i] ? 2'b00 : 2'b11;
			end
		end
	endfunction

	// control and architectural state
	reg [63:0] mask;
	reg [63:0] fe;
	reg [31:0] base;
	reg        mode64;
	reg        cap;
	reg        op;
	reg [2:0]  state;
	reg [7:0]  step;
	reg        hw;
	reg        hdr_wr;
	reg [63:0] sel;
	reg [63:0] vec;
	reg [15:0] fp_control_word;
	reg [15:0] fp_status_word;
	reg [15:0] fp_tag_word;
	reg [15:0] fop;
	reg [63:0] ip;
	reg [63:0] dp;
	reg [15:0] cs;
	reg [15:0] ds;
	reg [31:0] media_control_status;
	reg        lightweight_profiling;
	reg        aw_got;
	reg        w_got;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	wire        busy = (state != S_IDLE);
	wire [31:0] st_rdata;
	wire [7:0]  st_idx = step - `XSSR_STK_STEP;
	wire        pend = fp_status_word[`XSSR_FPSW_ES];
	wire        do_wr = aw_got & w_got & ~s_axi_bvalid;
	wire [7:0]  wr_ofs = {aw_addr[7:2], 2'b00};
	wire        st_we;
	wire [31:0] st_wdata;
	reg  [1:0]  act;
	reg  [31:0] save_word;
	reg  [31:0] rd_mux;
	reg         rd_err;
	reg  [63:0] next_fe;
	reg         wr_err;

	// what the current step does: skip, move a word, or load an initial value
	always @* begin
		act = A_SKIP;
		if (step == `XSSR_MCS_WORD || step == `XSSR_MXMASK_WORD) begin
			if (sel[`XSSR_FE_SSE] | sel[`XSSR_FE_UVH]) begin
				act = (!op || step == `XSSR_MCS_WORD) ? A_MEM : A_SKIP; // [RULE_13]
			end
		end else if (step < `XSSR_MED_STEP) begin
			if (sel[`XSSR_FE_X87]) begin // [RULE_08]
				if (op && !vec[`XSSR_FE_X87]) begin
					act = A_INIT; // [RULE_10]
				end else if (step >= 8'd2 && step <= 8'd5) begin
					act = (cap || pend) ? A_MEM : A_SKIP; // [RULE_14] [RULE_15] [RULE_16]
				end else begin
					act = A_MEM; // [RULE_09]
				end
			end
		end else if (step < `XSSR_UPH_STEP) begin
			if (sel[`XSSR_FE_SSE] && (mode64 || step < `XSSR_MED_STEP + 8'd32)) begin // [RULE_17]
				act = (op && !vec[`XSSR_FE_SSE]) ? A_INIT : A_MEM; // [RULE_11]
			end
		end else begin
			if (sel[`XSSR_FE_UVH] && (mode64 || step < `XSSR_UPH_STEP + 8'd32)) begin // [RULE_18]
				act = (op && !vec[`XSSR_FE_UVH]) ? A_INIT : A_MEM; // [RULE_12]
			end
		end
	end

	// word written to the image by a save; with cap set, pointers read as zero unless an error waits
	always @* begin
		case (step)
		8'd0: save_word = {fp_status_word, fp_control_word};
		8'd1: save_word = {fop, 8'h00, tag_abridge(fp_tag_word)};
		8'd2: save_word = ip[31:0];
		8'd3: save_word = mode64 ? ip[63:32] : {16'h0000, cs};
		8'd4: save_word = dp[31:0];
		8'd5: save_word = mode64 ? dp[63:32] : {16'h0000, ds};
		8'd6: save_word = media_control_status;
		8'd7: save_word = `XSSR_MXMASK;
		default: save_word = st_rdata;
		endcase
		if (step >= 8'd2 && step <= 8'd5 && cap && !pend) begin
			save_word = 32'h00000000; // [RULE_16]
		end
	end

	// image slots: stack from word 8, media from word 40, upper halves after the header
	assign st_we = (step >= `XSSR_STK_STEP) &&
		((state == S_LOAD && act == A_INIT) || (state == S_BUS && mem_ack && op)); // [RULE_20]
	assign st_wdata = (state == S_BUS) ? mem_rdata : 32'h00000000;

	xssr_state_mem u_mem (
		.clk   (clk),
		.we    (st_we),
		.waddr (st_idx),
		.wdata (st_wdata),
		.raddr (st_idx),
		.rdata (st_rdata)
	);

	// register read decode; unmapped offsets answer slverr
	always @* begin
		rd_err = 1'b0;
		case ({s_axi_araddr[7:2], 2'b00})
		`XSSR_REG_CTRL:    rd_mux = {23'h0, busy, 4'h0, cap, mode64, op, 1'b0};
		`XSSR_REG_MASK_LO: rd_mux = mask[31:0];
		`XSSR_REG_MASK_HI: rd_mux = mask[63:32];
		`XSSR_REG_FE_LO:   rd_mux = fe[31:0];
		`XSSR_REG_FE_HI:   rd_mux = fe[63:32];
		`XSSR_REG_BASE:    rd_mux = base;
		`XSSR_REG_FPU:     rd_mux = {fp_status_word, fp_control_word};
		`XSSR_REG_MCS:     rd_mux = media_control_status;
		`XSSR_REG_VEC_LO:  rd_mux = vec[31:0];
		`XSSR_REG_VEC_HI:  rd_mux = vec[63:32];
		default: begin
			rd_mux = 32'h00000000;
			rd_err = 1'b1;
		end
		endcase
	end

	// feature enable candidate; an illegal combination leaves the register as it was
	always @* begin
		next_fe = fe;
		wr_err = 1'b0;
		if (wr_ofs == `XSSR_REG_FE_LO) begin
			next_fe[31:0] = merge(fe[31:0], w_data, w_strb);
		end else if (wr_ofs == `XSSR_REG_FE_HI) begin
			next_fe[63:32] = merge(fe[63:32], w_data, w_strb);
		end
		if ((next_fe & ~`XSSR_FE_LEGAL) != 64'h0 || !next_fe[`XSSR_FE_X87] ||
			next_fe[2:1] == 2'b10) begin
			next_fe = fe;
		end
		if (wr_ofs > `XSSR_REG_VEC_HI) begin
			wr_err = 1'b1;
		end
	end

	// axi4-lite slave; address and data may arrive in either order
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `XSSR_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `XSSR_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= ~(aw_got | (s_axi_awready & s_axi_awvalid)) | do_wr;
			s_axi_wready <= ~(w_got | (s_axi_wready & s_axi_wvalid)) | do_wr;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_wr) begin
				w_got <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `XSSR_RESP_SLVERR : `XSSR_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_err ? `XSSR_RESP_SLVERR : `XSSR_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// configuration writes; ignored while an operation runs so it sees stable inputs
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask <= 64'h0;
			fe <= `XSSR_FE_RST;
			base <= 32'h00000000;
			mode64 <= 1'b0;
			cap <= 1'b0;
		end else if (do_wr && !busy) begin
			fe <= next_fe;
			case (wr_ofs)
			`XSSR_REG_MASK_LO: mask[31:0] <= merge(mask[31:0], w_data, w_strb);
			`XSSR_REG_MASK_HI: mask[63:32] <= merge(mask[63:32], w_data, w_strb);
			`XSSR_REG_BASE:    base <= merge(base, w_data, w_strb) & 32'hffff_fffc;
			`XSSR_REG_CTRL: begin
				if (w_strb[0]) begin
					mode64 <= w_data[`XSSR_CTRL_MODE64];
					cap <= w_data[`XSSR_CTRL_CAP];
				end
			end
			default: begin
			end
			endcase
		end
	end

	// save/restore sequencer: header read, body steps, header write back on save
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_IDLE;
			op <= 1'b0;
			step <= 8'd0;
			hw <= 1'b0;
			hdr_wr <= 1'b0;
			sel <= 64'h0;
			vec <= 64'h0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			fp_control_word <= `XSSR_FPCW_INIT;
			fp_status_word <= `XSSR_FPSW_INIT;
			fp_tag_word <= `XSSR_FPTW_INIT;
			fop <= 16'h0000;
			ip <= 64'h0;
			dp <= 64'h0;
			cs <= 16'h0000;
			ds <= 16'h0000;
			media_control_status <= `XSSR_MCS_RST;
			lightweight_profiling <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				if (do_wr && wr_ofs == `XSSR_REG_CTRL && w_strb[0] && w_data[`XSSR_CTRL_START]) begin
					op <= w_data[`XSSR_CTRL_OP];
					sel <= mask & fe; // [RULE_05] [RULE_08]
					hw <= 1'b0;
					hdr_wr <= 1'b0;
					state <= S_HREQ;
				end
			end
			S_HREQ: begin
				mem_req <= 1'b1;
				mem_we <= hdr_wr;
				mem_addr <= base + {22'h0, `XSSR_HDR_WORD + {7'h0, hw}, 2'b00}; // [RULE_01] [RULE_02]
				mem_wdata <= hw ? vec[63:32] : vec[31:0];
				state <= S_HWAIT;
			end
			S_HWAIT: begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					mem_we <= 1'b0;
					hw <= ~hw;
					if (!hdr_wr && !hw) begin
						vec[31:0] <= mem_rdata;
					end else if (!hdr_wr) begin
						vec[63:32] <= mem_rdata;
					end
					if (!hw) begin
						state <= S_HREQ;
					end else if (hdr_wr) begin
						state <= S_IDLE;
					end else begin
						if (op && sel[`XSSR_FE_PROF] && !mem_rdata[`XSSR_FE_PROF - 32]) begin
							lightweight_profiling <= 1'b0; // [RULE_10]
						end
						step <= 8'd0;
						state <= S_PREP;
					end
				end
			end
			S_PREP: begin
				// restore never visits the legacy words past the media slots, so software bytes stay untouched
				// step runs one past the last slot, so the last slot is moved exactly once
				if (step > `XSSR_LAST_STEP) begin
					// only a save writes the header back; a restore keeps the vector it read
					if (!op) begin
						vec <= (vec & ~sel) | // [RULE_03] [RULE_04] [RULE_05]
							(sel & {1'b0, lightweight_profiling, 59'h0, 3'b111});
					end
					hdr_wr <= 1'b1;
					state <= op ? S_IDLE : S_HREQ;
				end else if (act != A_SKIP) begin
					state <= S_LOAD; // [RULE_19]
				end else begin
					step <= step + 8'd1;
				end
			end
			S_LOAD: begin
				if (act == A_INIT) begin
					case (step)
					8'd0: begin
						fp_control_word <= `XSSR_FPCW_INIT;
						fp_status_word <= `XSSR_FPSW_INIT;
					end
					8'd1: begin
						fp_tag_word <= `XSSR_FPTW_INIT;
						fop <= 16'h0000;
					end
					8'd2: ip <= 64'h0;
					8'd3: cs <= 16'h0000;
					8'd4: dp <= 64'h0;
					8'd5: ds <= 16'h0000;
					default: begin
					end
					endcase
					state <= S_PREP;
					step <= step + 8'd1;
				end else begin
					mem_req <= 1'b1;
					mem_we <= ~op;
					mem_wdata <= save_word;
					mem_addr <= base + {22'h0, (step < `XSSR_UPH_STEP) ? step :
						(step - `XSSR_UPH_STEP + `XSSR_UPH_WORD), 2'b00};
					state <= S_BUS;
				end
			end
			S_BUS: begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					mem_we <= 1'b0;
					if (op) begin
						case (step)
						8'd0: begin
							fp_control_word <= mem_rdata[15:0]; // [RULE_09]
							fp_status_word <= mem_rdata[31:16];
						end
						8'd1: begin
							fp_tag_word <= tag_expand(mem_rdata[7:0]);
							fop <= mem_rdata[31:16];
						end
						8'd2: ip[31:0] <= mem_rdata;
						8'd3: begin
							ip[63:32] <= mode64 ? mem_rdata : 32'h00000000;
							cs <= mode64 ? 16'h0000 : mem_rdata[15:0]; // [RULE_15]
						end
						8'd4: dp[31:0] <= mem_rdata;
						8'd5: begin
							dp[63:32] <= mode64 ? mem_rdata : 32'h00000000;
							ds <= mode64 ? 16'h0000 : mem_rdata[15:0]; // [RULE_15]
						end
						8'd6: media_control_status <= mem_rdata; // [RULE_13]
						default: begin
						end
						endcase
					end
					step <= step + 8'd1;
					state <= S_PREP;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// [shared/xssr_consts.vh]
// constants of the extended state save and restore engine
// included by the engine and its state memory; definitions only
`ifndef XSSR_CONSTS_VH
`define XSSR_CONSTS_VH

// save area layout, in 32-bit word addresses relative to the area base
`define XSSR_HDR_WORD     8'd128
`define XSSR_UPH_WORD     8'd144
`define XSSR_MCS_WORD     8'd6
`define XSSR_MXMASK_WORD  8'd7

// sequencer step numbers: step n touches legacy word n up to the media slots
`define XSSR_STK_STEP     8'd8
`define XSSR_MED_STEP     8'd40
`define XSSR_UPH_STEP     8'd104
`define XSSR_LAST_STEP    8'd167
`define XSSR_ST_DEPTH     160

// feature bit positions, shared by the enable register and the present vector
`define XSSR_FE_X87       0
`define XSSR_FE_SSE       1
`define XSSR_FE_UVH       2
`define XSSR_FE_PROF      62
`define XSSR_FE_RST       64'h0000000000000001
`define XSSR_FE_LEGAL     64'h4000000000000007
`define XSSR_FPSW_ES      7

// initial values
`define XSSR_FPCW_INIT    16'h037f
`define XSSR_FPSW_INIT    16'h0000
`define XSSR_FPTW_INIT    16'hffff
`define XSSR_MCS_RST      32'h00001f80
`define XSSR_MXMASK       32'h0000ffbf

// register byte offsets
`define XSSR_REG_CTRL     8'h00
`define XSSR_REG_MASK_LO  8'h04
`define XSSR_REG_MASK_HI  8'h08
`define XSSR_REG_FE_LO    8'h0c
`define XSSR_REG_FE_HI    8'h10
`define XSSR_REG_BASE     8'h14
`define XSSR_REG_FPU      8'h18
`define XSSR_REG_MCS      8'h1c
`define XSSR_REG_VEC_LO   8'h20
`define XSSR_REG_VEC_HI   8'h24

// control register fields
`define XSSR_CTRL_START   0
`define XSSR_CTRL_OP      1
`define XSSR_CTRL_MODE64  2
`define XSSR_CTRL_CAP     3
`define XSSR_CTRL_BUSY    8

`define XSSR_RESP_OKAY    2'b00
`define XSSR_RESP_SLVERR  2'b10

`endif

// [verilog/xssr_state_mem.v]
// register image memory: stack, media and upper-half slots, one word each entry
// assumes a single clock; read data are registered, one cycle after the address
`timescale 1ns/1ps
`include "xssr_consts.vh"

module xssr_state_mem (
	input  wire        clk,
	input  wire        we,
	input  wire [7:0]  waddr,
	input  wire [31:0] wdata,
	input  wire [7:0]  raddr,
	output reg  [31:0] rdata
);
	reg [31:0] mem [0:`XSSR_ST_DEPTH-1];

	// no reset on the array: contents are architectural state set by restores
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// [tb/xssr_props_properties.sv]
// port checker for the save/restore engine: memory port and axi4-lite slave
// assumes a save area base aligned to 4 KiB, so word index is addr[11:2]
`timescale 1ns/1ps
module xssr_props (
	input wire        clk,
	input wire        sys_rst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        mem_req,
	input wire        mem_we,
	input wire [31:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire        mem_ack
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// a request stands whole until memory answers, then drops
	property p_req_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request moved before ack");
	property p_req_drop;
		mem_req && mem_ack |=> !mem_req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("memory request held after ack");
	property p_align;
		mem_req |-> mem_addr[1:0] == 2'h0;
	endproperty
	a_align: assert property (p_align) else $error("unaligned save area word");
	// the spare legacy bytes are never touched by either operation
	property p_ign;
		mem_req |-> !(mem_addr[11:2] >= 10'h074 && mem_addr[11:2] <= 10'h07f);
	endproperty
	a_ign: assert property (p_ign) else $error("spare legacy bytes accessed");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped early");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");
	property p_blat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_blat: assert property (p_blat) else $error("write answer not two cycles on");
	// readies drop for the cycle after a taken write and return with the response
	property p_rdy;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
			!s_axi_awready && !s_axi_wready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("write ready held after handshake");

	c_hdr_wr: cover property (mem_req && mem_we && mem_addr[11:2] == 10'h080);
	c_hdr_rd: cover property (mem_req && !mem_we && mem_addr[11:2] == 10'h080);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind xssr_top xssr_props xssr_props_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
	.mem_we, .mem_addr, .mem_wdata, .mem_ack);

// [tb/xssr_mem_model.sv]
// behavioural save area memory on the engine's word port
// assumes the area lies in the low 4 KiB; slow adds three wait cycles
`timescale 1ns/1ps
module xssr_mem_model (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        slow,
	input  wire        mem_req,
	input  wire        mem_we,
	input  wire [31:0] mem_addr,
	input  wire [31:0] mem_wdata,
	output reg  [31:0] mem_rdata,
	output reg         mem_ack
);
	reg [31:0] mem [0:1023];
	reg [1:0]  wait_cnt;

	// one-cycle ack; data flip outside it so a stale word never passes
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (slow && wait_cnt != 2'h3) begin
					wait_cnt <= wait_cnt + 2'h1;
				end else begin
					wait_cnt <= 2'h0;
					mem_ack <= 1'b1;
					if (mem_we)
						mem[mem_addr[11:2]] <= mem_wdata;
					else
						mem_rdata <= mem[mem_addr[11:2]];
				end
			end
		end
	end
endmodule

// [tb/tb_top.sv]
// self-checking bench: axi4-lite master tasks drive save and restore runs
// assumes save area base 0, so memory word n sits at byte 4*n
`timescale 1ns/1ps
module tb_top;
	reg         clk, sys_rst, slow;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg  [3:0]  s_axi_wstrb;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
	wire        mem_req, mem_we, mem_ack;
	reg  [31:0] rd_data;
	reg  [1:0]  rd_resp;
	reg         done;
	integer     n_errors, compares, n, k, i, cnt_med, cnt_uph, cnt_ign, cnt_ep;

	xssr_top xssr_top_i (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack);
	xssr_mem_model xssr_mem_model_i (.clk, .sys_rst, .slow, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack);

	// count finished words by region; the start write on the control word clears them
	always @(posedge clk) begin
		if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00) begin
			cnt_med <= 0;
			cnt_uph <= 0;
			cnt_ign <= 0;
			cnt_ep <= 0;
		end else if (mem_req && mem_ack) begin
			if (mem_addr[11:2] >= 72 && mem_addr[11:2] <= 103) cnt_med <= cnt_med + 1;
			if (mem_addr[11:2] >= 176 && mem_addr[11:2] <= 207) cnt_uph <= cnt_uph + 1;
			if (mem_addr[11:2] >= 116 && mem_addr[11:2] <= 127) cnt_ign <= cnt_ign + 1;
			if (mem_addr[11:2] >= 2 && mem_addr[11:2] <= 5 && mem_we) cnt_ep <= cnt_ep + 1;
		end
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task test_done;
		begin
			if (n_errors == 0 && compares > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// a used-up bound counts as a mismatch and ends the run
	task lim(input integer c, input integer b);
		if (c >= b) begin
			n_errors = n_errors + 1;
			test_done;
		end
	endtask
	task axi_wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			done = 1'b0;
			for (n = 0; n < 400 && !done; n = n + 1) begin
				@(posedge clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) begin
					s_axi_bready <= 1'b0;
					rd_resp = s_axi_bresp;
					done = 1'b1;
				end
			end
			lim(!done, 1);
		end
	endtask
	task axi_rd(input [7:0] a);
		begin
			@(posedge clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			done = 1'b0;
			for (n = 0; n < 400 && !done; n = n + 1) begin
				@(posedge clk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) begin
					s_axi_rready <= 1'b0;
					rd_data = s_axi_rdata;
					rd_resp = s_axi_rresp;
					done = 1'b1;
				end
			end
			lim(!done, 1);
		end
	endtask
	task chk(input [7:0] a, input [31:0] exp);
		begin
			axi_rd(a);
			check(rd_data, exp);
		end
	endtask
	// start an operation and poll busy until it clears
	task op(input [31:0] ctrl);
		begin
			axi_wr(8'h00, ctrl);
			rd_data = 32'h100;
			for (k = 0; k < 2000 && rd_data[8] !== 1'b0; k = k + 1) axi_rd(8'h00);
			lim(k, 2000);
		end
	endtask
	task pk(input integer a, input [31:0] v);
		xssr_mem_model_i.mem[a] = v;
	endtask
	function [31:0] mw(input integer a);
		mw = xssr_mem_model_i.mem[a];
	endfunction

	initial begin
		sys_rst = 1'b1;
		slow = 1'b0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		n_errors = 0;
		compares = 0;
		for (i = 0; i < 1024; i = i + 1) pk(i, 32'h0);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		// reset values, refused writes and an unmapped place
		chk(8'h18, 32'h0000037f);
		chk(8'h1c, 32'h00001f80);
		chk(8'h0c, 32'h00000001);
		chk(8'h28, 32'h0);
		check({30'h0, rd_resp}, 32'h2);
		axi_wr(8'h0c, 32'h7);
		axi_wr(8'h0c, 32'h6);
		chk(8'h0c, 32'h7);
		axi_wr(8'h30, 32'h1);
		check({30'h0, rd_resp}, 32'h2);
		axi_wr(8'h04, 32'h7);
		// full restore in 64-bit mode from a slow memory
		pk(0, 32'h00001234);
		pk(2, 32'h11110000);
		pk(6, 32'h00001f00);
		pk(8, 32'ha5a50001);
		pk(40, 32'h5a5a0002);
		pk(72, 32'h5a5a0003);
		pk(176, 32'hc3c30005);
		pk(128, 32'h7);
		slow <= 1'b1;
		op(32'hf);
		chk(8'h18, 32'h00001234);
		chk(8'h1c, 32'h00001f00);
		chk(8'h20, 32'h7);
		check(cnt_ign, 0);
		// save into a poisoned area, no pending error
		slow <= 1'b0;
		for (i = 0; i < 256; i = i + 1) pk(i, 32'hffffffff);
		pk(128, 32'h0);
		pk(129, 32'h40000000);
		op(32'hd); // plain save in 64-bit mode with cap set
		check(mw(8), 32'ha5a50001);
		check(mw(40), 32'h5a5a0002);
		check(mw(176), 32'hc3c30005);
		check(cnt_med, 32);
		check(mw(2), 32'h0);
		check(mw(128), 32'h7);
		check(mw(129), 32'h40000000);
		// x87-only save keeps other present bits and media control word
		axi_wr(8'h04, 32'h1);
		pk(128, 32'h4);
		pk(6, 32'hdead0000);
		op(32'h1);
		check(mw(128), 32'h5);
		check(mw(6), 32'hdead0000);
		check(cnt_ep, 0);
		// restore with present bits clear outside 64-bit mode
		axi_wr(8'h04, 32'h6);
		pk(128, 32'h0);
		pk(6, 32'h00001f01);
		op(32'h3);
		check(cnt_med + cnt_uph, 0);
		chk(8'h1c, 32'h00001f01);
		chk(8'h18, 32'h00001234);
		axi_wr(8'h04, 32'h7);
		op(32'h5);
		check(mw(40), 32'h0);
		check(mw(72), 32'h5a5a0003);
		check(mw(144), 32'h0);
		check(mw(176), 32'hc3c30005);
		// x87 initial values, then pointers carried by a pending error
		axi_wr(8'h04, 32'h1);
		pk(128, 32'h0);
		op(32'h3);
		chk(8'h18, 32'h0000037f);
		pk(0, 32'h00801234);
		pk(2, 32'h22220000);
		pk(128, 32'h1);
		op(32'h3);
		pk(2, 32'h0);
		op(32'h9);
		check(mw(2), 32'h22220000);
		test_done;
	end
endmodule
